// [shared/dsd_map.vh]
// constants for the dual sigma-delta mode decoder and output multiplexer
// assumes inclusion by bare name from the design files; definitions only
`ifndef DSD_MAP_VH
`define DSD_MAP_VH

// four decoded levels of a bootstrap pin, code is {low-phase, high-phase} sample
`define DSD_LVL_GND 2'h0
`define DSD_LVL_CLOCK 2'h1
`define DSD_LVL_INVERTED_CLOCK_LEVEL 2'h2
`define DSD_LVL_VCC 2'h3

// pin positions inside the four-pin vector
`define DSD_PIN_PREC 0
`define DSD_PIN_REF 1
`define DSD_PIN_OUT 2
`define DSD_PIN_MODE 3

// configuration vector layout
`define DSD_CFG_W 40
`define DSD_CFG_GAIN_LSB 0
`define DSD_CFG_PREC_BIT 2
`define DSD_CFG_REF_LSB 3
`define DSD_CFG_TEST_BIT 5
`define DSD_CFG_OUT_LSB 6
`define DSD_CFG_SWAP_BIT 8
`define DSD_CFG_RESET 40'h0000000000

// current-channel gain codes: 2, 4, 8, 16
`define DSD_GAIN_2 2'h0
`define DSD_GAIN_16 2'h3

// output multiplexer modes
`define DSD_OUT_MUXED 2'h0
`define DSD_OUT_CURR_A 2'h1
`define DSD_OUT_CURR_B 2'h2
`define DSD_OUT_SPLIT 2'h3

// register offsets (byte addresses)
`define DSD_REG_STATUS 4'h0
`define DSD_REG_CTRL 4'h4
`define DSD_REG_CFG_LO 4'h8
`define DSD_REG_CFG_HI 4'hC

// register fields
`define DSD_ST_SOFT 0
`define DSD_ST_RSVD 1
`define DSD_ST_VALID 2
`define DSD_ST_CAPT 3
`define DSD_ST_CODES_LSB 4
`define DSD_CTRL_OUTEN 0
`define DSD_CTRL_RECAP 1
`define DSD_CTRL_RESET 1'h1

`endif

// [verilog/dsd_pin_decode.v]
// four-level bootstrap pin decoder: gnd, vcc, clock, inverted clock
// assumes pins and extClk are synchronous to sys_clk and extClk is far slower
`timescale 1ns/1ps
`include "dsd_map.vh"

module dsd_pin_decode #(
  parameter NPINS = 4,
  parameter STABLE = 4,
  parameter CW = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // sampled external clock and pins
  input wire extClk,
  input wire [NPINS-1:0] pinIn,
  // decoded codes and per-pin stability
  output reg [2*NPINS-1:0] pinCode,
  output reg [NPINS-1:0] pinValid
);

  reg clkD_r;
  reg [NPINS-1:0] pinD_r;
  reg [NPINS-1:0] hiSmp_r;
  reg [CW-1:0] cnt_r [0:NPINS-1];
  wire clkRise;
  wire clkFall;
  integer i;

  assign clkRise = extClk & ~clkD_r;
  assign clkFall = ~extClk & clkD_r;

  // samples taken one cycle before each edge, so a pin that follows the
  // clock is never caught mid-transition
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      clkD_r <= 1'b0;
      pinD_r <= {NPINS{1'b0}};
      hiSmp_r <= {NPINS{1'b0}};
      pinCode <= {2*NPINS{1'b0}};
      pinValid <= {NPINS{1'b0}};
      for (i = 0; i < NPINS; i = i + 1)
        cnt_r[i] <= {CW{1'b0}};
    end
    else
    begin
      clkD_r <= extClk;
      pinD_r <= pinIn;
      if (clkFall)
        hiSmp_r <= pinD_r;
      if (clkRise)
      begin
        for (i = 0; i < NPINS; i = i + 1)
        begin
          pinCode[2*i +: 2] <= {pinD_r[i], hiSmp_r[i]};
          // a code must repeat for STABLE+1 clock periods before it counts
          if (pinCode[2*i +: 2] != {pinD_r[i], hiSmp_r[i]})
          begin
            cnt_r[i] <= {CW{1'b0}};
            pinValid[i] <= 1'b0;
          end
          else if (cnt_r[i] != STABLE[CW-1:0])
            cnt_r[i] <= cnt_r[i] + {{(CW-1){1'b0}}, 1'b1};
          else
            pinValid[i] <= 1'b1;
        end
      end
    end
  end

endmodule // dsd_pin_decode

// [verilog/dsd_mode_mux.v]
// mode decoder, soft configuration port and output stream multiplexer
// assumes extClk, pins and modulator bits are synchronous to sys_clk
`timescale 1ns/1ps
`include "dsd_map.vh"

module dsd_mode_mux #(
  parameter STABLE = 4,
  parameter CFG_W = 40
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // external modulator clock
  input wire extClk,
  // bootstrap pins
  input wire precisionGainPin,
  input wire refCurvePin,
  input wire outputSelectPin,
  input wire modeSelectPin,
  // modulator comparator bits
  input wire voltModBit,
  input wire currModBit,
  // register port
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // settings to the analog front end
  output reg lowPrecisionSetting,
  output reg [1:0] currGainSel,
  output reg [1:0] refCurveSel,
  output reg selfTestEn,
  output reg voltChanEn,
  output reg softModeActive,
  // output streams
  output reg primaryStreamOut,
  output reg secondaryStreamOut
);

  // one-hot mode states
  localparam [3:0] ST_WAIT = 4'h1;
  localparam [3:0] ST_HARD = 4'h2;
  localparam [3:0] ST_SOFT = 4'h4;
  localparam [3:0] ST_RSVD = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [CFG_W-1:0] hardCfg_r;
  reg [CFG_W-1:0] softCfg_r;
  reg [CFG_W-1:0] shift_r;
  reg [5:0] bitCnt_r;
  reg sclD_r;
  reg enD_r;
  reg clkD_r;
  reg voltageBitstream_r;
  reg currentBitstream_r;
  reg outEn_r;
  reg captured_r;
  reg capture;
  reg [CFG_W-1:0] activeCfg;
  reg [1:0] outMode;
  reg primNxt;
  reg secNxt;
  wire [7:0] pinCode;
  wire [3:0] pinValid;
  wire [1:0] modeCode;
  wire modeValid;
  wire allValid;
  wire sclRise;
  wire enFall;
  wire recapReq;

  // decodes all four pins with one shared clock-edge tracker
  dsd_pin_decode #(
    .NPINS(4),
    .STABLE(STABLE),
    .CW(3)
  ) u_decode (
    .sys_clk(sys_clk),
    .srst(srst),
    .extClk(extClk),
    .pinIn({modeSelectPin, outputSelectPin, refCurvePin, precisionGainPin}),
    .pinCode(pinCode),
    .pinValid(pinValid)
  );

  assign modeCode = pinCode[2*`DSD_PIN_MODE +: 2];
  assign modeValid = pinValid[`DSD_PIN_MODE];
  assign allValid = &pinValid;
  assign recapReq = regWr & (regAddr == `DSD_REG_CTRL) & regWdata[`DSD_CTRL_RECAP];

  // packs the pin codes of hard mode into the configuration layout
  function [CFG_W-1:0] packHard;
    input [7:0] codes;
    reg [1:0] prec;
    reg [CFG_W-1:0] v;
    begin
      prec = codes[2*`DSD_PIN_PREC +: 2];
      v = `DSD_CFG_RESET;
      // gnd and vcc select gain 16, the two clock phases select gain 2
      if (prec == `DSD_LVL_GND || prec == `DSD_LVL_VCC)
        v[`DSD_CFG_GAIN_LSB +: 2] = `DSD_GAIN_16;
      else
        v[`DSD_CFG_GAIN_LSB +: 2] = `DSD_GAIN_2;
      v[`DSD_CFG_PREC_BIT] = (prec == `DSD_LVL_GND) | (prec == `DSD_LVL_CLOCK);
      v[`DSD_CFG_REF_LSB +: 2] = codes[2*`DSD_PIN_REF +: 2];
      v[`DSD_CFG_OUT_LSB +: 2] = codes[2*`DSD_PIN_OUT +: 2];
      v[`DSD_CFG_TEST_BIT] = (codes[2*`DSD_PIN_MODE +: 2] == `DSD_LVL_VCC);
      packHard = v;
    end
  endfunction

  // mode selection; the mode pin steers it, and leaving ST_WAIT also needs every pin valid
  always @*
  begin
    state_nxt = state_r;
    capture = 1'b0;
    case (state_r)
      ST_WAIT:
      begin
        // startup: wait until every bootstrap level has settled
        if (allValid)
        begin
          capture = 1'b1;
          if (modeCode == `DSD_LVL_CLOCK)
            state_nxt = ST_SOFT;
          else if (modeCode == `DSD_LVL_INVERTED_CLOCK_LEVEL)
            state_nxt = ST_RSVD;
          else
            state_nxt = ST_HARD;
        end
      end
      ST_HARD:
      begin
        if (modeValid && modeCode == `DSD_LVL_CLOCK)
          state_nxt = ST_SOFT;
        else if (modeValid && modeCode == `DSD_LVL_INVERTED_CLOCK_LEVEL)
          state_nxt = ST_RSVD;
        else if (recapReq && allValid)
          capture = 1'b1;
      end
      ST_SOFT, ST_RSVD:
      begin
        // back to hard mode takes a fresh snapshot of the pins
        if (modeValid && modeCode == `DSD_LVL_CLOCK)
          state_nxt = ST_SOFT;
        else if (modeValid && modeCode == `DSD_LVL_INVERTED_CLOCK_LEVEL)
          state_nxt = ST_RSVD;
        else if (modeValid)
          state_nxt = ST_WAIT;
      end
      default:
        state_nxt = ST_WAIT;
    endcase
  end

  // state and hard snapshot
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= ST_WAIT;
      hardCfg_r <= `DSD_CFG_RESET;
      captured_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (capture)
      begin
        hardCfg_r <= packHard(pinCode);
        captured_r <= 1'b1;
      end
    end
  end

  assign sclRise = precisionGainPin & ~sclD_r;
  assign enFall = ~outputSelectPin & enD_r;

  // serial configuration port: precision pin clocks, reference pin carries
  // data msb first, output-select pin frames; the mode pin stays the clock
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      sclD_r <= 1'b0;
      enD_r <= 1'b0;
      shift_r <= `DSD_CFG_RESET;
      bitCnt_r <= 6'h00;
      softCfg_r <= `DSD_CFG_RESET;
    end
    else
    begin
      sclD_r <= precisionGainPin;
      enD_r <= outputSelectPin;
      if (state_r == ST_SOFT)
      begin
        if (outputSelectPin && sclRise)
        begin
          shift_r <= {shift_r[CFG_W-2:0], refCurvePin};
          // counts one past a full frame so an overlong frame never commits
          if (bitCnt_r != CFG_W[5:0] + 6'h01)
            bitCnt_r <= bitCnt_r + 6'h01;
        end
        // a short or long frame is dropped so old settings survive intact
        if (enFall)
        begin
          if (bitCnt_r == CFG_W[5:0])
            softCfg_r <= shift_r;
          bitCnt_r <= 6'h00;
        end
      end
      else
        bitCnt_r <= 6'h00;
    end
  end

  // active configuration, soft vector or hard snapshot
  always @*
  begin
    if (state_r == ST_SOFT)
      activeCfg = softCfg_r;
    else
      activeCfg = hardCfg_r;
    outMode = activeCfg[`DSD_CFG_OUT_LSB +: 2];
  end

  // resample modulator bits on the external clock rising edge; both
  // channels share the edge so their samples stay aligned
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      clkD_r <= 1'b0;
      voltageBitstream_r <= 1'b0;
      currentBitstream_r <= 1'b0;
    end
    else
    begin
      clkD_r <= extClk;
      if (extClk && !clkD_r)
      begin
        voltageBitstream_r <= voltModBit;
        currentBitstream_r <= currModBit;
      end
    end
  end

  // output multiplexer
  always @*
  begin
    case (outMode)
      `DSD_OUT_MUXED:
      begin
        // follows the sampled clock level, so it lags the pin by one cycle
        primNxt = clkD_r ? voltageBitstream_r : currentBitstream_r;
        secNxt = ~primNxt;
      end
      `DSD_OUT_SPLIT:
      begin
        primNxt = voltageBitstream_r;
        secNxt = currentBitstream_r;
      end
      default:
      begin
        primNxt = currentBitstream_r;
        secNxt = ~currentBitstream_r;
      end
    endcase
    // soft-only option swaps the two pins
    if (state_r == ST_SOFT && activeCfg[`DSD_CFG_SWAP_BIT])
    begin
      primNxt = primNxt ^ secNxt;
      secNxt = primNxt ^ secNxt;
      primNxt = primNxt ^ secNxt;
    end
  end

  // registered outputs; streams parked low unless output enable is set in hard or soft mode
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      primaryStreamOut <= 1'b0;
      secondaryStreamOut <= 1'b0;
      lowPrecisionSetting <= 1'b1;
      currGainSel <= `DSD_GAIN_2;
      refCurveSel <= 2'h0;
      selfTestEn <= 1'b0;
      voltChanEn <= 1'b0;
      softModeActive <= 1'b0;
    end
    else
    begin
      if (outEn_r && (state_r == ST_HARD || state_r == ST_SOFT))
      begin
        primaryStreamOut <= primNxt;
        secondaryStreamOut <= secNxt;
      end
      else
      begin
        primaryStreamOut <= 1'b0;
        secondaryStreamOut <= 1'b0;
      end
      lowPrecisionSetting <= activeCfg[`DSD_CFG_PREC_BIT];
      currGainSel <= activeCfg[`DSD_CFG_GAIN_LSB +: 2];
      refCurveSel <= activeCfg[`DSD_CFG_REF_LSB +: 2];
      selfTestEn <= activeCfg[`DSD_CFG_TEST_BIT];
      voltChanEn <= (outMode == `DSD_OUT_MUXED) | (outMode == `DSD_OUT_SPLIT);
      softModeActive <= (state_r == ST_SOFT);
    end
  end

  // register port: control write, one-cycle-late read data
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      outEn_r <= `DSD_CTRL_RESET;
      regRdata <= 32'h00000000;
    end
    else
    begin
      if (regWr && regAddr == `DSD_REG_CTRL)
        outEn_r <= regWdata[`DSD_CTRL_OUTEN];
      regRdata <= 32'h00000000;
      if (regRd)
      begin
        case (regAddr)
          `DSD_REG_STATUS:
          begin
            regRdata[`DSD_ST_SOFT] <= (state_r == ST_SOFT);
            regRdata[`DSD_ST_RSVD] <= (state_r == ST_RSVD);
            regRdata[`DSD_ST_VALID] <= allValid;
            regRdata[`DSD_ST_CAPT] <= captured_r;
            regRdata[`DSD_ST_CODES_LSB +: 8] <= pinCode;
          end
          `DSD_REG_CTRL:
            regRdata[`DSD_CTRL_OUTEN] <= outEn_r;
          `DSD_REG_CFG_LO:
            regRdata <= activeCfg[31:0];
          `DSD_REG_CFG_HI:
            regRdata[CFG_W-33:0] <= activeCfg[CFG_W-1:32];
          default:
            regRdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // dsd_mode_mux

// [verilog/dsd_spare.v]
// holds no logic; the block lives in dsd_mode_mux.v and dsd_pin_decode.v

// [test/dsd_mode_mux_asserts.sv]
// checker on the ports of the mode decoder and stream multiplexer
// assumes one sys_clk domain and attachment by the bind at the foot
`timescale 1ns/1ps
module dsd_mode_mux_chk (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // pins and register port
  input wire extClk,
  input wire modeSelectPin,
  input wire [3:0] regAddr,
  input wire regRd,
  input wire [31:0] regRdata,
  // settings and streams
  input wire lowPrecisionSetting,
  input wire [1:0] currGainSel,
  input wire selfTestEn,
  input wire voltChanEn,
  input wire softModeActive,
  input wire primaryStreamOut,
  input wire secondaryStreamOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // reset must park streams even while it is held
  a_reset_park: assert property (disable iff (1'b0)
    srst |=> !primaryStreamOut && !secondaryStreamOut && !softModeActive && lowPrecisionSetting)
    else $error("streams or mode not parked by reset");
  a_soft_pin: assert property (softModeActive |-> modeSelectPin == extClk)
    else $error("soft mode without mode pin following the clock");
  a_hard_gain: assert property (!softModeActive |-> currGainSel == 2'h0 || currGainSel == 2'h3)
    else $error("hard mode gain outside 2 and 16");
  a_test_mode: assert property ($rose(selfTestEn) && !softModeActive |-> modeSelectPin)
    else $error("self test raised without mode pin at supply");
  // voltage channel off means secondary is the inverse of primary, settled two cycles
  a_curr_inverse: assert property (
    !voltChanEn && !$past(voltChanEn) && !$past(voltChanEn, 2)
    && (primaryStreamOut || secondaryStreamOut) |-> primaryStreamOut != secondaryStreamOut)
    else $error("secondary stream not inverse of primary");
  a_read_window: assert property (regRdata != 32'h0 |-> $past(regRd))
    else $error("read data outside its single cycle");
  a_unmapped_zero: assert property (regRd && regAddr[1:0] != 2'h0 |=> regRdata == 32'h0)
    else $error("unmapped address read nonzero");
  a_status_soft: assert property (
    regRd && regAddr == 4'h0 |=> regRdata[0] == softModeActive)
    else $error("status soft flag differs from mode");
  c_soft: cover property ($rose(softModeActive));
  c_test: cover property ($rose(selfTestEn));
  c_cfg_read: cover property (regRd && regAddr == 4'hC);
endmodule // dsd_mode_mux_chk

bind dsd_mode_mux dsd_mode_mux_chk i_chk (.sys_clk(sys_clk), .srst(srst), .extClk(extClk),
  .modeSelectPin(modeSelectPin), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .lowPrecisionSetting(lowPrecisionSetting), .currGainSel(currGainSel),
  .selfTestEn(selfTestEn), .voltChanEn(voltChanEn), .softModeActive(softModeActive),
  .primaryStreamOut(primaryStreamOut), .secondaryStreamOut(secondaryStreamOut));

// [test/dsd_dsp_model.sv]
// model of the metering processor that clocks and reads the streams
// assumes it shares sys_clk with the bench; extClk changes after an edge
`timescale 1ns/1ps
module dsd_dsp_model #(
  parameter HALF = 13
) (
  // clock
  input wire sys_clk,
  // modulator clock to the device
  output reg extClk,
  // streams from the device
  input wire primaryStreamOut,
  input wire secondaryStreamOut,
  // pair taken at each clock phase
  output reg [1:0] lastPair
);
  integer cnt = 0;
  initial extClk = 1'b0;
  initial lastPair = 2'h0;
  // HALF 13 gives about 3.8 MHz; four times HALF would be low power
  always @(posedge sys_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
    begin
      extClk <= ~extClk;
      lastPair <= {primaryStreamOut, secondaryStreamOut};
    end
  end
endmodule // dsd_dsp_model

// [test/dsd_mode_mux_tb.sv]
// self-checking bench for the mode decoder and stream multiplexer
// assumes the processor model makes extClk from the same sys_clk
`timescale 1ns/1ps
module dsd_mode_mux_tb;
  localparam HALF = 13;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg [1:0] lvl [0:3];
  reg voltModBit = 1'b1;
  reg currModBit = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [31:0] regWdata = 32'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  wire extClk;
  wire [3:0] pins;
  wire [31:0] regRdata;
  wire [1:0] currGainSel, refCurveSel, lastPair;
  wire lowPrecisionSetting, selfTestEn, voltChanEn, softModeActive;
  wire primaryStreamOut, secondaryStreamOut;
  integer fails = 0;
  integer checked = 0;
  integer i;
  reg [31:0] v;

  always #5 sys_clk = ~sys_clk;

  // level code: 0 ground, 1 clock, 2 inverted clock, 3 supply
  function pinLevel(input [1:0] l, input c);
    pinLevel = l[1] ? (l[0] | ~c) : (l[0] & c);
  endfunction
  assign pins[0] = pinLevel(lvl[0], extClk);
  assign pins[1] = pinLevel(lvl[1], extClk);
  assign pins[2] = pinLevel(lvl[2], extClk);
  assign pins[3] = pinLevel(lvl[3], extClk);

  dsd_mode_mux #(.STABLE(1)) i_dut (.sys_clk(sys_clk), .srst(srst), .extClk(extClk),
    .precisionGainPin(pins[0]), .refCurvePin(pins[1]), .outputSelectPin(pins[2]),
    .modeSelectPin(pins[3]), .voltModBit(voltModBit), .currModBit(currModBit),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .lowPrecisionSetting(lowPrecisionSetting),
    .currGainSel(currGainSel), .refCurveSel(refCurveSel), .selfTestEn(selfTestEn),
    .voltChanEn(voltChanEn), .softModeActive(softModeActive),
    .primaryStreamOut(primaryStreamOut), .secondaryStreamOut(secondaryStreamOut));
  dsd_dsp_model #(.HALF(HALF)) i_dsp (.sys_clk(sys_clk), .extClk(extClk),
    .primaryStreamOut(primaryStreamOut), .secondaryStreamOut(secondaryStreamOut),
    .lastPair(lastPair));

  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // waits whole extClk periods, as pin decode counts in periods
  task waitp(input integer n);
    repeat (n * 2 * HALF) @(posedge sys_clk);
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
  begin
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  end
  endtask
  // recapture needs the new pin level decoded first
  task recap;
  begin
    waitp(5);
    wr(4'h4, 32'h3);
    waitp(3);
  end
  endtask
  task send(input integer n, input [39:0] d);
    integer k;
  begin
    @(posedge sys_clk);
    lvl[2] <= 2'h3;
    for (k = 0; k < n; k = k + 1)
    begin
      repeat (2) @(posedge sys_clk);
      lvl[1] <= (k < 40 && d[39 - k]) ? 2'h3 : 2'h0;
      repeat (2) @(posedge sys_clk);
      lvl[0] <= 2'h3;
      repeat (2) @(posedge sys_clk);
      lvl[0] <= 2'h0;
    end
    repeat (2) @(posedge sys_clk);
    lvl[2] <= 2'h0;
    repeat (4) @(posedge sys_clk);
  end
  endtask

  task t_hard;
  begin
    rd(4'h0);
    chk(v, 32'h37C);
    chk(32'({lowPrecisionSetting, currGainSel, refCurveSel}), 32'hD);
    lvl[0] <= 2'h0;
    waitp(6);
    chk(32'({lowPrecisionSetting, currGainSel}), 32'h3);
    for (i = 0; i < 4; i = i + 1)
    begin
      lvl[0] <= i[1:0];
      recap;
      chk(32'({lowPrecisionSetting, currGainSel}),
        32'({i < 2, (i == 0 || i == 3) ? 2'h3 : 2'h0}));
    end
    for (i = 1; i < 4; i = i + 1)
    begin
      lvl[2] <= i[1:0];
      recap;
      chk(32'({voltChanEn, primaryStreamOut, secondaryStreamOut}),
        (i == 3) ? 32'h6 : 32'h1);
    end
    voltModBit <= 1'b0;
    currModBit <= 1'b1;
    waitp(2);
    chk(32'({primaryStreamOut, secondaryStreamOut}), 32'h1);
    wr(4'h4, 32'h0);
    waitp(1);
    chk(32'({primaryStreamOut, secondaryStreamOut}), 32'h0);
    rd(4'h4);
    chk(v, 32'h0);
    wr(4'h4, 32'h1);
    rd(4'h2);
    chk(v, 32'h0);
    $display("test hard mode done");
  end
  endtask

  task t_modes;
  begin
    lvl[3] <= 2'h3;
    recap;
    chk(32'(selfTestEn), 32'h1);
    lvl[3] <= 2'h2;
    recap;
    rd(4'h0);
    chk(v & 32'h3, 32'h2);
    chk(32'({primaryStreamOut, secondaryStreamOut}), 32'h0);
    $display("test mode pin done");
  end
  endtask

  task t_soft;
  begin
    voltModBit <= 1'b1;
    currModBit <= 1'b0;
    lvl[0] <= 2'h0;
    lvl[2] <= 2'h0;
    lvl[3] <= 2'h1;
    for (i = 0; i < 2000 && softModeActive !== 1'b1; i = i + 1)
      @(posedge sys_clk);
    chk(32'(softModeActive), 32'h1);
    send(40, 40'hA500000036);
    rd(4'h8);
    chk(v, 32'h36);
    rd(4'hC);
    chk(v, 32'hA5);
    chk(32'({lowPrecisionSetting, currGainSel, refCurveSel, selfTestEn}), 32'h35);
    send(39, 40'h0);
    rd(4'h8);
    chk(v, 32'h36);
    send(41, 40'h0);
    rd(4'h8);
    chk(v, 32'h36);
    @(posedge extClk);
    repeat (4) @(posedge sys_clk);
    #1 chk(32'({primaryStreamOut, secondaryStreamOut}), 32'h2);
    chk(32'(lastPair), 32'h1);
    @(negedge extClk);
    repeat (4) @(posedge sys_clk);
    #1 chk(32'({primaryStreamOut, secondaryStreamOut}), 32'h1);
    chk(32'(lastPair), 32'h2);
    // current-only output with the soft swap option set
    send(40, 40'h0000000140);
    rd(4'h8);
    chk(v, 32'h140);
    chk(32'({voltChanEn, primaryStreamOut, secondaryStreamOut}), 32'h2);
    $display("test soft mode done");
  end
  endtask

  task report_and_stop;
  begin
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // pins start as hard mode, split outputs, high precision gain 16
  initial
  begin
    lvl[0] = 2'h3;
    lvl[1] = 2'h1;
    lvl[2] = 2'h3;
    lvl[3] = 2'h0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    waitp(8);
    t_hard;
    t_modes;
    t_soft;
    report_and_stop;
  end

  // whole run is near 35 us; the limit leaves a wide margin
  initial
  begin
    #400000;
    fails = fails + 1;
    report_and_stop;
  end
endmodule // dsd_mode_mux_tb
